// File: bench/pfs_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_mac_model
  import pfs_pkg::*;
(
  // clock
  input  wire logic             i_clk,
  // transmit events
  output logic                  o_tx,
  output logic [4:0]            o_coll,
  output logic                  o_exc,
  output logic                  o_late,
  // receive events
  output logic                  o_rx,
  output logic [LEN_W-1:0]      o_len,
  output logic                  o_crc
);
  initial begin
    {o_tx, o_exc, o_late, o_rx, o_crc, o_coll, o_len} = '0;
  end
  // collision count, length and crc flag inverted once released, so a stale value is never trusted
  task automatic tx(input logic [4:0] c, input logic e, input logic l);
    @(posedge i_clk);
    #1;
    {o_tx, o_coll, o_exc, o_late} = {~e, c, e, l};
    @(posedge i_clk);
    #1;
    {o_tx, o_coll, o_exc, o_late} = {1'b0, ~c, 2'b00};
  endtask : tx
  task automatic rx(input logic [LEN_W-1:0] n, input logic e);
    @(posedge i_clk);
    #1;
    {o_rx, o_len, o_crc} = {1'b1, n, e};
    @(posedge i_clk);
    #1;
    {o_rx, o_len, o_crc} = {1'b0, ~n, ~e};
  endtask : rx
endmodule : pfs_mac_model
`default_nettype wire

// File: bench/pfs_stats_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_stats_top_test;
  import pfs_pkg::*;
  logic I_SYS_CLK = 0, I_RSTN = 0, I_CE = 1, I_SNAP = 0;
  logic tx, exc, late, rx, crc, done;
  logic [4:0] coll;
  logic [LEN_W-1:0] len;
  logic [NUM_CNT-1:0][31:0] snap;
  int errors = 0, n_compared = 0, k;
  int exp_c[NUM_CNT];
  int exp_s[NUM_CNT];
  int lens[16] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024,
                   1518, 1519, 1536, 1537, 20};
  always #2 I_SYS_CLK = ~I_SYS_CLK;
  pfs_mac_model m (.i_clk(I_SYS_CLK), .o_tx(tx), .o_coll(coll), .o_exc(exc),
    .o_late(late), .o_rx(rx), .o_len(len), .o_crc(crc));
  pfs_stats_top uut (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE),
    .I_TX_DONE(tx), .I_TX_COLL_CNT(coll), .I_TX_EXCESS(exc),
    .I_TX_LATE_COLL(late), .I_RX_DONE(rx), .I_RX_LEN(len),
    .I_RX_CRC_ERR(crc), .I_SNAP(I_SNAP), .O_SNAP(snap),
    .O_SNAP_DONE(done));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      errors++;
      $display("BAD %s exp %0h seen %0h", what, expv, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // oversize beyond the configured maximum lands in no bin
  function automatic int bin_of(input int l);
    if (l < 64) return C_RUNT;
    if (l == 64) return C_B64;
    if (l <= 127) return C_B127;
    if (l <= 255) return C_B255;
    if (l <= 511) return C_B511;
    if (l <= 1023) return C_B1023;
    if (l <= 1518) return C_B1518;
    if (l <= int'(MAX_FRAME_DEF)) return C_GIANT;
    return -1;
  endfunction : bin_of
  task automatic do_tx(input int c, input bit e, input bit l);
    m.tx(c[4:0], e, l);
    if (!I_CE) return;
    if (e) exp_c[C_EXCESS]++;
    else if (c == 1) exp_c[C_SINGLE]++;
    else if (c >= 2) exp_c[C_MULTI]++;
    if (l) exp_c[C_LATE]++;
  endtask : do_tx
  task automatic do_rx(input int l, input bit e);
    m.rx(l[LEN_W-1:0], e);
    if (!I_CE) return;
    if (e) exp_c[C_CRC]++;
    if (bin_of(l) >= 0) exp_c[bin_of(l)]++;
  endtask : do_rx
  // expectation frozen when the request goes up, so events that land on
  // the snapshot edge belong to the next read
  task automatic snap_chk;
    @(posedge I_SYS_CLK);
    #1 I_SNAP = 1;
    exp_s = exp_c;
    @(posedge I_SYS_CLK);
    #1 I_SNAP = 0;
    for (int i = 0; i < 4 && done !== 1'b1; i++) @(posedge I_SYS_CLK) #1;
    if (done !== 1'b1) begin
      errors++;
      wrap_up();
    end else begin
      for (int i = 0; i < NUM_CNT; i++)
        check($sformatf("cnt%0d", i), snap[i], exp_s[i]);
      @(posedge I_SYS_CLK) #1;
      check("done_fall", done, 1'b0);
    end
  endtask : snap_chk
  initial begin
    k = $urandom(17647);
    repeat (3) @(posedge I_SYS_CLK);
    #1 I_RSTN = 1;
    snap_chk();
    foreach (lens[i]) do_rx(lens[i], i[0]);
    for (int c = 0; c < 4; c++) do_tx(c * 10 % 32, 0, c[0]);
    do_tx(1, 0, 1);
    do_tx(7, 1, 0);
    repeat (60) begin
      fork
        do_rx($urandom_range(1600, 20), $urandom_range(1, 0));
        do_tx($urandom_range(31, 0), $urandom_range(1, 0),
              $urandom_range(1, 0));
      join
    end
    snap_chk();
    // a snapshot taken with events captures the counts before them
    fork
      do_rx(64, 1);
      snap_chk();
    join
    snap_chk();
    // a frozen block loses events without a sign
    I_CE = 0;
    do_rx(100, 1);
    do_tx(1, 0, 1);
    I_CE = 1;
    snap_chk();
    @(posedge I_SYS_CLK);
    #1 I_RSTN = 0;
    repeat (2) @(posedge I_SYS_CLK);
    #1 I_RSTN = 1;
    exp_c = '{default: 0};
    check("done_rst", done, 1'b0);
    for (int i = 0; i < NUM_CNT; i++)
      check($sformatf("rst%0d", i), snap[i], 32'h0);
    snap_chk();
    wrap_up();
  end
endmodule : pfs_stats_top_test
`default_nettype wire

// File: hw/pfs_len_class.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_len_class
  import pfs_pkg::*;
(
  // frame length
  input  wire logic [LEN_W-1:0]   i_len,
  input  wire logic [LEN_W-1:0]   i_max,
  // one bin per class, at most one set
  output logic      [NUM_BIN-1:0] o_bin
);
  always_comb begin
    o_bin = '0;
    o_bin[B_RUNT] = (i_len < LEN_MIN);
    o_bin[B_64] = (i_len == LEN_MIN);
    o_bin[B_127] = (i_len > LEN_MIN) && (i_len <= LEN_127);
    o_bin[B_255] = (i_len > LEN_127) && (i_len <= LEN_255);
    o_bin[B_511] = (i_len > LEN_255) && (i_len <= LEN_511);
    o_bin[B_1023] = (i_len > LEN_511) && (i_len <= LEN_1023);
    o_bin[B_1518] = (i_len > LEN_1023) && (i_len <= LEN_1518);
    // frames above the maximum fall in no bin
    o_bin[B_GIANT] = (i_len >= LEN_GIANT) && (i_len <= i_max);
  end
endmodule : pfs_len_class
`default_nettype wire

// File: hw/pfs_pkg.sv
package pfs_pkg;
  localparam int LEN_W = 16;
  localparam int NUM_CNT = 13;
  localparam int NUM_BIN = 8;
  // counter indices
  localparam int C_SINGLE = 0;
  localparam int C_MULTI = 1;
  localparam int C_EXCESS = 2;
  localparam int C_LATE = 3;
  localparam int C_CRC = 4;
  localparam int C_RUNT = 5;
  localparam int C_B64 = 6;
  localparam int C_B127 = 7;
  localparam int C_B255 = 8;
  localparam int C_B511 = 9;
  localparam int C_B1023 = 10;
  localparam int C_B1518 = 11;
  localparam int C_GIANT = 12;
  // bin positions inside the classifier output
  localparam int B_RUNT = 0;
  localparam int B_64 = 1;
  localparam int B_127 = 2;
  localparam int B_255 = 3;
  localparam int B_511 = 4;
  localparam int B_1023 = 5;
  localparam int B_1518 = 6;
  localparam int B_GIANT = 7;
  // length bounds in octets
  localparam logic [LEN_W-1:0] LEN_MIN = 16'h0040;
  localparam logic [LEN_W-1:0] LEN_127 = 16'h007F;
  localparam logic [LEN_W-1:0] LEN_255 = 16'h00FF;
  localparam logic [LEN_W-1:0] LEN_511 = 16'h01FF;
  localparam logic [LEN_W-1:0] LEN_1023 = 16'h03FF;
  localparam logic [LEN_W-1:0] LEN_1518 = 16'h05EE;
  localparam logic [LEN_W-1:0] LEN_GIANT = 16'h05EF;
  localparam logic [LEN_W-1:0] MAX_FRAME_DEF = 16'h0600;
  // collision count of a single-collision frame
  localparam int COLL_ONE = 1;
  // late collision boundary in bit times, judged by the mac
  localparam int LATE_COLL_BITS = 512;
endpackage : pfs_pkg

// File: hw/pfs_stats_top.sv
// Overview of operation
// - a frame sent after exactly one collision bumps the single counter.
// - a frame sent after two or more collisions bumps the multiple counter.
// - a frame abandoned at the retry limit bumps the excessive counter.
// - each collision after the first 512 bit times bumps the late counter.
// - each received frame with a bad check sequence bumps the crc counter.
// - each received frame under 64 octets bumps the runt counter, crc or not.
// - each received frame of exactly 64 octets bumps the first length bin.
// - frames of 65 to 127 and of 128 to 255 octets have their own bins.
// - frames of 256 to 511 and of 512 to 1023 octets have their own bins.
// - frames of 1024 to 1518 octets have their own bin.
// - frames from 1519 octets to the maximum frame size count as giant.
// - every received frame up to the maximum frame size is binned by length, bad frames included.
`timescale 1ns/1ps
`default_nettype none
module pfs_stats_top
  import pfs_pkg::*;
#(
  parameter int               CW        = 32,
  parameter int               CCW       = 5,
  parameter logic [LEN_W-1:0] MAX_FRAME = MAX_FRAME_DEF
)(
  // clock and reset
  input  wire logic                          I_SYS_CLK,
  input  wire logic                          I_RSTN,
  input  wire logic                          I_CE,
  // transmit events
  input  wire logic                          I_TX_DONE,
  input  wire logic [CCW-1:0]                I_TX_COLL_CNT,
  input  wire logic                          I_TX_EXCESS,
  input  wire logic                          I_TX_LATE_COLL,
  // receive events
  input  wire logic                          I_RX_DONE,
  input  wire logic [LEN_W-1:0]              I_RX_LEN,
  input  wire logic                          I_RX_CRC_ERR,
  // management read
  input  wire logic                          I_SNAP,
  output logic      [NUM_CNT-1:0][CW-1:0]    O_SNAP,
  output logic                               O_SNAP_DONE
);

  typedef struct packed {
    logic [NUM_CNT-1:0][CW-1:0] cnt;
    logic [NUM_CNT-1:0][CW-1:0] snap;
    logic                       snap_vld;
  } pfs_state_t;

  pfs_state_t         st_r;
  pfs_state_t         st_nxt;
  logic [NUM_BIN-1:0] bin;
  logic [NUM_CNT-1:0] ev;

  function automatic logic [CW-1:0] pfs_inc(input logic [CW-1:0] v);
    return v + CW'(1);
  endfunction : pfs_inc

  pfs_len_class u_len_class (
    .i_len (I_RX_LEN),
    .i_max (MAX_FRAME),
    .o_bin (bin)
  );

  // each event maps to one counter, so one step per event
  always_comb begin
    ev = '0;
    ev[C_SINGLE] = I_TX_DONE && (I_TX_COLL_CNT == CCW'(COLL_ONE));
    ev[C_MULTI] = I_TX_DONE && (I_TX_COLL_CNT > CCW'(COLL_ONE));
    ev[C_EXCESS] = I_TX_EXCESS;
    ev[C_LATE] = I_TX_LATE_COLL;
    ev[C_CRC] = I_RX_DONE && I_RX_CRC_ERR;
    // crc status not looked at: bad frames are binned too
    ev[C_RUNT] = I_RX_DONE && bin[B_RUNT];
    ev[C_B64] = I_RX_DONE && bin[B_64];
    ev[C_B127] = I_RX_DONE && bin[B_127];
    ev[C_B255] = I_RX_DONE && bin[B_255];
    ev[C_B511] = I_RX_DONE && bin[B_511];
    ev[C_B1023] = I_RX_DONE && bin[B_1023];
    ev[C_B1518] = I_RX_DONE && bin[B_1518];
    ev[C_GIANT] = I_RX_DONE && bin[B_GIANT];
  end

  always_comb begin
    st_nxt = st_r;
    if (I_CE) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (ev[i]) begin
          st_nxt.cnt[i] = pfs_inc(st_r.cnt[i]);
        end
      end
      // snapshot keeps reads coherent while counting goes on
      st_nxt.snap_vld = I_SNAP;
      if (I_SNAP) begin
        st_nxt.snap = st_r.cnt;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_SNAP = st_r.snap;
  assign O_SNAP_DONE = st_r.snap_vld;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  a_single_count: assert property (
    I_CE && I_TX_DONE && I_TX_COLL_CNT == CCW'(COLL_ONE)
    |=> st_r.cnt[C_SINGLE] == CW'($past(st_r.cnt[C_SINGLE]) + 1))
    else $error("single collision count did not step");

  a_multi_count: assert property (
    I_CE && I_TX_DONE && I_TX_COLL_CNT > CCW'(COLL_ONE)
    |=> st_r.cnt[C_MULTI] == CW'($past(st_r.cnt[C_MULTI]) + 1))
    else $error("multiple collision count did not step");

  a_no_coll_kept: assert property (
    I_CE && I_TX_DONE && I_TX_COLL_CNT == '0
    |=> $stable(st_r.cnt[C_SINGLE]) && $stable(st_r.cnt[C_MULTI]))
    else $error("collision-free frame changed collision counts");

  a_excess_count: assert property (
    I_CE && I_TX_EXCESS
    |=> st_r.cnt[C_EXCESS] == CW'($past(st_r.cnt[C_EXCESS]) + 1))
    else $error("excessive collision count did not step");

  a_late_count: assert property (
    I_CE && I_TX_LATE_COLL
    |=> st_r.cnt[C_LATE] == CW'($past(st_r.cnt[C_LATE]) + 1))
    else $error("late collision count did not step");

  a_crc_count: assert property (
    I_CE && I_RX_DONE && I_RX_CRC_ERR
    |=> st_r.cnt[C_CRC] == CW'($past(st_r.cnt[C_CRC]) + 1))
    else $error("crc error count did not step");

  a_runt_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN < LEN_MIN
    |=> st_r.cnt[C_RUNT] == CW'($past(st_r.cnt[C_RUNT]) + 1))
    else $error("runt count did not step");

  a_bin64_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN == LEN_MIN
    |=> st_r.cnt[C_B64] == CW'($past(st_r.cnt[C_B64]) + 1))
    else $error("64 octet bin did not step");

  a_bin1518_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN == LEN_1518
    |=> st_r.cnt[C_B1518] == CW'($past(st_r.cnt[C_B1518]) + 1)
        && $stable(st_r.cnt[C_GIANT]))
    else $error("1518 octet frame binned wrongly");

  a_giant_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN == LEN_GIANT
    |=> st_r.cnt[C_GIANT] == CW'($past(st_r.cnt[C_GIANT]) + 1))
    else $error("giant count did not step");

  // frames above the configured maximum fall in no bin by design
  a_one_bin: assert property (
    I_RX_DONE && I_RX_LEN <= MAX_FRAME |-> $onehot(bin))
    else $error("received frame not in exactly one bin");

  a_freeze_ce: assert property (
    !I_CE |=> $stable(st_r))
    else $error("state moved while clock enable low");

  a_snap_hold: assert property (
    !(I_CE && I_SNAP) ##1 !(I_CE && I_SNAP) |=> $stable(O_SNAP))
    else $error("snapshot changed without a request");

  a_snap_copy: assert property (
    I_CE && I_SNAP |=> O_SNAP == $past(st_r.cnt) && O_SNAP_DONE)
    else $error("snapshot does not match counters");

  a_snap_done_pulse: assert property (
    I_CE && !I_SNAP |=> !O_SNAP_DONE)
    else $error("snapshot done stood without a request");

  a_no_tx_kept: assert property (
    I_CE && !I_TX_DONE
    |=> $stable(st_r.cnt[C_SINGLE]) && $stable(st_r.cnt[C_MULTI]))
    else $error("collision counts moved without a sent frame");

  a_crc_clean: assert property (
    I_CE && !(I_RX_DONE && I_RX_CRC_ERR) |=> $stable(st_r.cnt[C_CRC]))
    else $error("crc count moved without a bad frame");

  a_runt_crc_both: assert property (
    I_CE && I_RX_DONE && I_RX_CRC_ERR && I_RX_LEN < LEN_MIN
    |=> st_r.cnt[C_RUNT] == CW'($past(st_r.cnt[C_RUNT]) + 1)
        && st_r.cnt[C_CRC] == CW'($past(st_r.cnt[C_CRC]) + 1))
    else $error("bad runt frame not counted twice");

  a_bin127_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN > LEN_MIN && I_RX_LEN <= LEN_127
    |=> st_r.cnt[C_B127] == CW'($past(st_r.cnt[C_B127]) + 1))
    else $error("65 to 127 octet bin did not step");

  a_bin255_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN > LEN_127 && I_RX_LEN <= LEN_255
    |=> st_r.cnt[C_B255] == CW'($past(st_r.cnt[C_B255]) + 1))
    else $error("128 to 255 octet bin did not step");

  a_bin511_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN > LEN_255 && I_RX_LEN <= LEN_511
    |=> st_r.cnt[C_B511] == CW'($past(st_r.cnt[C_B511]) + 1))
    else $error("256 to 511 octet bin did not step");

  a_bin1023_count: assert property (
    I_CE && I_RX_DONE && I_RX_LEN > LEN_511 && I_RX_LEN <= LEN_1023
    |=> st_r.cnt[C_B1023] == CW'($past(st_r.cnt[C_B1023]) + 1))
    else $error("512 to 1023 octet bin did not step");

  // oversize frames vanish from the histogram, only crc still sees them
  a_over_max_drop: assert property (
    I_CE && I_RX_DONE && I_RX_LEN > MAX_FRAME
    |=> $stable(st_r.cnt[C_GIANT]) && $stable(st_r.cnt[C_B1518]))
    else $error("frame above the maximum was binned");

  c_single: cover property (I_CE && ev[C_SINGLE]);
  c_late_and_rx: cover property (I_CE && ev[C_LATE] && I_RX_DONE);
  c_giant_crc: cover property (I_CE && ev[C_GIANT] && ev[C_CRC]);
  c_snap_busy: cover property (I_CE && I_SNAP && |ev);

endmodule : pfs_stats_top
`default_nettype wire
